// [hw/udrt_pkg.sv]
// constants and types shared by the up/down reload timer
package udrt_pkg;

  // ****************************************
  // register map (printed offsets are indices)
  // ****************************************
  localparam int ADDR_W = 18;
  localparam logic [15:0] MODE_IDX = 16'hffb4;
  localparam logic [15:0] COUNT_IDX = 16'hffb5;
  localparam logic [15:0] CTRL_IDX = 16'hffb0;
  localparam logic [ADDR_W-1:0] MODE_ADDR = {MODE_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] COUNT_ADDR = {COUNT_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] CTRL_ADDR = {CTRL_IDX, 2'h0};

  // ****************************************
  // reset values and field positions
  // ****************************************
  localparam logic [7:0] MODE_RST = 8'h18;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] RELOAD_RST = 8'h00;
  localparam logic [1:0] MODE_RSV = 2'h3;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] COUNT_MIN = 8'h00;
  localparam int CTRL_FLAG_BIT = 0;
  localparam int CTRL_IEN_BIT = 1;
  localparam int CTRL_EDGE_BIT = 2;

  // ****************************************
  // clock select codes and prescaler
  // ****************************************
  localparam logic [2:0] SEL_WATCH = 3'h6;
  localparam logic [2:0] SEL_EVENT = 3'h7;
  localparam int PRESC_W = 13;
  localparam int NUM_DIV = 6;
  localparam logic [NUM_DIV*PRESC_W-1:0] DIV_MASKS = {
    13'h0003, 13'h000f, 13'h003f, 13'h01ff, 13'h07ff, 13'h1fff};
  localparam logic [1:0] WATCH_DIV_LAST = 2'h3;

  typedef struct packed {
    logic reloadSelect;
    logic hwDirection;
    logic swDirection;
    logic [1:0] reserved;
    logic [2:0] clockSel;
  } udrt_mode_t;

  typedef struct packed {
    logic [ADDR_W-1:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } udrt_apb_req_t;

endpackage

// [hw/udrt_timer.sv]
// 8-bit up/down interval / auto-reload timer with apb registers
// Function
// - reload-select 0 gives free-running interval timer
// - reset: counter 00, mode register 18
// - three-bit select picks clock source
// - overflow or underflow sets flag, interrupt if enabled
// - interval mode wraps to 00 or FF
// - reload write also loads counter immediately
// - reload-select 1 reloads counter on wrap
// - reload period spans 1 to 256 clocks
// - auto-reload shares clock, direction, flag behaviour
// - select 111 counts chosen event pin edge
// - hardware direction: pin low up, high down
// - watch clock synchronised, one-cycle count error
// - sub-clock modes count only watch or event
// - select encodes divisions 8192 down to event
// - direction field 00 up, 01 down, 1x pin
// - counter read and reload write share address
`timescale 1ns/1ns
`default_nettype none
module udrt_timer (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // apb slave
  input wire logic [udrt_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins and watch clock, asynchronous
  input wire logic eventPin,
  input wire logic dirPin,
  input wire logic watchClk,
  // power state
  input wire logic haltReq,
  input wire logic subClockMode,
  // interrupt request
  output logic irqOut
);

  // ****************************************
  // apb decode
  // ****************************************
  udrt_pkg::udrt_apb_req_t req;
  assign req = '{paddr: paddr, psel: psel, penable: penable, pwrite: pwrite, pwdata: pwdata};

  logic access;
  logic hitMode;
  logic hitCount;
  logic hitCtrl;
  logic wrMode;
  logic wrReload;
  logic wrCtrl;
  assign access = ce && req.psel && req.penable && pready;
  assign hitMode = req.paddr == udrt_pkg::MODE_ADDR;
  assign hitCount = req.paddr == udrt_pkg::COUNT_ADDR;
  assign hitCtrl = req.paddr == udrt_pkg::CTRL_ADDR;
  assign wrMode = access && req.pwrite && hitMode;
  assign wrReload = access && req.pwrite && hitCount;
  assign wrCtrl = access && req.pwrite && hitCtrl;

  udrt_pkg::udrt_mode_t mode;
  logic [7:0] counterValue;
  logic [7:0] reloadValue;
  logic overflowRequestFlag;
  logic overflowIrqEnable;
  logic eventRising;

  // one wait state: ready comes a cycle into the access phase
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (ce) begin
      pready <= req.psel && req.penable && !pready;
      pslverr <= req.psel && req.penable && !pready && !(hitMode || hitCount || hitCtrl);
      if (req.psel && req.penable && !pready && !req.pwrite) begin
        if (hitMode) begin
          prdata <= {24'h0, mode};
        end else if (hitCount) begin
          prdata <= {24'h0, counterValue};
        end else if (hitCtrl) begin
          prdata <= {29'h0, eventRising, overflowIrqEnable, overflowRequestFlag};
        end else begin
          prdata <= 32'h0;
        end
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  // mode register keeps its value in every halted state
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode <= udrt_pkg::MODE_RST;
    end else if (wrMode) begin
      mode <= {req.pwdata[7:5], udrt_pkg::MODE_RSV, req.pwdata[2:0]};
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reloadValue <= udrt_pkg::RELOAD_RST;
    end else if (wrReload) begin
      reloadValue <= req.pwdata[7:0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      overflowIrqEnable <= 1'b0;
      eventRising <= 1'b1;
    end else if (wrCtrl) begin
      overflowIrqEnable <= req.pwdata[udrt_pkg::CTRL_IEN_BIT];
      eventRising <= req.pwdata[udrt_pkg::CTRL_EDGE_BIT];
    end
  end

  // ****************************************
  // pin and watch clock synchronisers
  // ****************************************
  // three stages; the filtered level moves only when stages two and three agree
  logic [2:0] evtSync;
  logic [2:0] dirSync;
  logic [2:0] wSync;
  logic evtLvl;
  logic evtPrev;
  logic dirLvl;
  logic wLvl;
  logic wPrev;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      evtSync <= 3'h0;
      dirSync <= 3'h0;
      wSync <= 3'h0;
    end else if (ce) begin
      evtSync <= {evtSync[1:0], eventPin};
      dirSync <= {dirSync[1:0], dirPin};
      wSync <= {wSync[1:0], watchClk};
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      evtLvl <= 1'b0;
      evtPrev <= 1'b0;
      dirLvl <= 1'b0;
      wLvl <= 1'b0;
      wPrev <= 1'b0;
    end else if (ce) begin
      if (evtSync[1] == evtSync[2]) begin
        evtLvl <= evtSync[2];
      end
      if (dirSync[1] == dirSync[2]) begin
        dirLvl <= dirSync[2];
      end
      if (wSync[1] == wSync[2]) begin
        wLvl <= wSync[2];
      end
      evtPrev <= evtLvl;
      wPrev <= wLvl;
    end
  end

  logic eventEdge;
  assign eventEdge = eventRising ? (evtLvl && !evtPrev) : (!evtLvl && evtPrev);

  // watch clock divided by four, counted in the system domain
  logic [1:0] wDiv;
  logic watchTick;
  assign watchTick = wLvl && !wPrev && wDiv == udrt_pkg::WATCH_DIV_LAST;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wDiv <= 2'h0;
    end else if (ce && wLvl && !wPrev) begin
      wDiv <= wDiv + 2'h1;
    end
  end

  // ****************************************
  // prescaler
  // ****************************************
  logic [udrt_pkg::PRESC_W-1:0] presc;
  logic [udrt_pkg::NUM_DIV-1:0] divTick;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      presc <= '0;
    end else if (ce) begin
      presc <= presc + 1'b1;
    end
  end

  // entry k ticks once every period of its division
  for (genvar k = 0; k < udrt_pkg::NUM_DIV; k++) begin : g_div
    localparam logic [udrt_pkg::PRESC_W-1:0] MASK =
      udrt_pkg::DIV_MASKS[k*udrt_pkg::PRESC_W +: udrt_pkg::PRESC_W];
    assign divTick[k] = (presc & MASK) == MASK;
  end

  // ****************************************
  // count enable and direction
  // ****************************************
  logic srcTick;
  always_comb begin
    case (mode.clockSel)
      udrt_pkg::SEL_WATCH: srcTick = watchTick;
      udrt_pkg::SEL_EVENT: srcTick = eventEdge;
      default: srcTick = divTick[mode.clockSel];
    endcase
  end

  logic subAllowed;
  logic cntTick;
  logic countUp;
  logic wrapHit;
  // all six prescaler taps are ignored when the system clock is the sub clock
  assign subAllowed = !subClockMode || mode.clockSel == udrt_pkg::SEL_WATCH ||
                      mode.clockSel == udrt_pkg::SEL_EVENT;
  assign cntTick = ce && srcTick && subAllowed && !haltReq;
  assign countUp = mode.hwDirection ? !dirLvl : !mode.swDirection;
  assign wrapHit = countUp ? counterValue == udrt_pkg::COUNT_MAX :
                             counterValue == udrt_pkg::COUNT_MIN;

  // ****************************************
  // counter
  // ****************************************
  // a software load wins over a count in the same cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      counterValue <= udrt_pkg::COUNT_RST;
    end else if (wrReload) begin
      counterValue <= req.pwdata[7:0];
    end else if (cntTick) begin
      if (wrapHit && mode.reloadSelect) begin
        counterValue <= reloadValue;
      end else if (countUp) begin
        counterValue <= counterValue + 8'h01;
      end else begin
        counterValue <= counterValue - 8'h01;
      end
    end
  end

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      overflowRequestFlag <= 1'b0;
    end else if (cntTick && wrapHit) begin
      overflowRequestFlag <= 1'b1;
    end else if (wrCtrl && req.pwdata[udrt_pkg::CTRL_FLAG_BIT]) begin
      overflowRequestFlag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irqOut <= 1'b0;
    end else if (ce) begin
      irqOut <= overflowRequestFlag && overflowIrqEnable;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_mode_reserved: assert property (mode.reserved == udrt_pkg::MODE_RSV)
    else $error("mode reserved bits not ones");
  a_wrap_up: assert property (cntTick && !wrReload && countUp && !mode.reloadSelect &&
      counterValue == udrt_pkg::COUNT_MAX |=> counterValue == udrt_pkg::COUNT_MIN)
    else $error("up wrap did not return to zero");
  a_wrap_down: assert property (cntTick && !wrReload && !countUp && !mode.reloadSelect &&
      counterValue == udrt_pkg::COUNT_MIN |=> counterValue == udrt_pkg::COUNT_MAX)
    else $error("down wrap did not return to max");
  a_auto_reload: assert property (cntTick && !wrReload && wrapHit && mode.reloadSelect
      |=> counterValue == $past(reloadValue))
    else $error("reload value not loaded on wrap");
  a_write_load: assert property (wrReload |=> counterValue == $past(pwdata[7:0]))
    else $error("reload write did not load counter");
  a_flag_irq: assert property (cntTick && wrapHit && overflowIrqEnable && !wrCtrl
      |=> overflowRequestFlag ##1 (irqOut || !$past(ce)))
    else $error("wrap did not raise flag and interrupt");
  a_halt_freeze: assert property (haltReq && !wrReload |=> $stable(counterValue))
    else $error("counter moved while halted");
  a_sub_gate: assert property (subClockMode && !wrReload &&
      mode.clockSel < udrt_pkg::SEL_WATCH |=> $stable(counterValue))
    else $error("counter moved on fast clock in sub mode");
  a_hw_down: assert property (cntTick && !wrReload && mode.hwDirection && dirLvl &&
      counterValue != udrt_pkg::COUNT_MIN |=> counterValue == $past(counterValue) - 8'h01)
    else $error("pin high did not count down");

  c_overflow: cover property (cntTick && wrapHit && countUp);
  c_underflow: cover property (cntTick && wrapHit && !countUp && mode.reloadSelect);
  c_event_count: cover property (cntTick && mode.clockSel == udrt_pkg::SEL_EVENT);
  c_watch_count: cover property (cntTick && subClockMode);

endmodule
`default_nettype wire

// [tb/udrt_pins_model.sv]
// pin-side partner: event pin, direction pin and watch clock sources
`timescale 1ns/1ns
`default_nettype none
module udrt_pins_model (
  // system clock and watch clock gate
  input wire logic ref_clk,
  input wire logic watchRun,
  // pins toward the timer
  output logic eventPin,
  output logic dirPin,
  output logic watchClk
);
  // ****************************************
  // pin drivers
  // ****************************************
  initial begin
    eventPin = 1'b0;
    dirPin = 1'b0;
    watchClk = 1'b0;
  end

  // 104 ns half period never lands on a rising ref_clk edge and spans at least two samples,
  // so the pin filter never drops a level; it stands still when gated
  always #104 if (watchRun) watchClk = ~watchClk;

  // software has enabled the event pin function and masked the pin irq beforehand
  // each level is held eight clocks so the pin filter settles before the next change
  task automatic event_level(input logic lvl);
    @(posedge ref_clk);
    eventPin <= lvl;
    repeat (8) @(posedge ref_clk);
  endtask

  task automatic pulse_event(input int n);
    for (int i = 0; i < n; i++) begin
      event_level(1'b1);
      event_level(1'b0);
    end
  endtask

  // direction pin function enabled by software before use
  task automatic set_dir(input logic down);
    @(posedge ref_clk);
    dirPin <= down;
    repeat (8) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// [tb/test_udrt_timer.sv]
// self-checking bench for the up/down reload timer
`timescale 1ns/1ns
`default_nettype none
module test_udrt_timer;
  // ****************************************
  // signals
  // ****************************************
  localparam logic [udrt_pkg::ADDR_W-1:0] MODE = udrt_pkg::MODE_ADDR;
  localparam logic [udrt_pkg::ADDR_W-1:0] CNT = udrt_pkg::COUNT_ADDR;
  localparam logic [udrt_pkg::ADDR_W-1:0] CTRL = udrt_pkg::CTRL_ADDR;
  localparam logic [udrt_pkg::ADDR_W-1:0] BAD = 18'h00100;
  logic ref_clk;
  logic rst;
  logic ceRun;
  logic [udrt_pkg::ADDR_W-1:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irqOut;
  logic haltReq;
  logic subClockMode;
  logic watchRun;
  logic eventPin;
  logic dirPin;
  logic watchClk;
  logic [31:0] rd;
  logic err;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;
  int divs[6] = '{8192, 2048, 512, 64, 16, 4};

  always #20 ref_clk = ~ref_clk;

  udrt_timer dut (.ref_clk(ref_clk), .rst(rst), .ce(ceRun), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .eventPin(eventPin), .dirPin(dirPin), .watchClk(watchClk),
    .haltReq(haltReq), .subClockMode(subClockMode), .irqOut(irqOut));

  udrt_pins_model pins (.ref_clk(ref_clk), .watchRun(watchRun), .eventPin(eventPin),
    .dirPin(dirPin), .watchClk(watchClk));

  // ****************************************
  // tasks
  // ****************************************
  // request stands until the edge that samples pready high; data are taken at that edge
  task automatic apb(input logic [udrt_pkg::ADDR_W-1:0] a, input logic w, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rd_check(input logic [udrt_pkg::ADDR_W-1:0] a, input logic [31:0] exp,
    input string name);
    apb(a, 1'b0, 32'h0);
    check(name, exp, rd);
  endtask

  task automatic irq_check(input logic exp);
    repeat (2) @(negedge ref_clk);
    check("irq", {31'h0, exp}, {31'h0, irqOut});
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // hang guard: whole run is near 33k cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    ceRun = 1'b1;
    paddr = '0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = '0;
    haltReq = 1'b0;
    subClockMode = 1'b0;
    watchRun = 1'b0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd_check(MODE, 32'h18, "mode reset");
    rd_check(CNT, 32'h00, "count reset");
    rd_check(CTRL, 32'h04, "ctrl reset");
    rd_check(BAD, 32'h0, "unmapped");
    check("slverr", 32'h1, {31'h0, err});
    apb(MODE, 1'b1, 32'h07);
    apb(CNT, 1'b1, 32'hfe);
    rd_check(CNT, 32'hfe, "reload load");
    pins.pulse_event(2);
    rd_check(CNT, 32'h00, "wrap up");
    rd_check(CTRL, 32'h05, "ovf flag");
    apb(CTRL, 1'b1, 32'h06);
    irq_check(1'b1);
    apb(CTRL, 1'b1, 32'h07);
    irq_check(1'b0);
    apb(MODE, 1'b1, 32'h27);
    apb(CNT, 1'b1, 32'h01);
    pins.pulse_event(2);
    rd_check(CNT, 32'hff, "wrap down");
    rd_check(CTRL, 32'h07, "unf flag");
    apb(MODE, 1'b1, 32'h87);
    apb(CTRL, 1'b1, 32'h07);
    apb(CNT, 1'b1, 32'hfe);
    pins.pulse_event(2);
    rd_check(CNT, 32'hfe, "auto reload");
    apb(CTRL, 1'b1, 32'h07);
    apb(CNT, 1'b1, 32'hff);
    pins.pulse_event(1);
    rd_check(CTRL, 32'h07, "period one");
    apb(MODE, 1'b1, 32'hc7);
    pins.set_dir(1'b1);
    apb(CNT, 1'b1, 32'h01);
    pins.pulse_event(2);
    rd_check(CNT, 32'h01, "hw down reload");
    pins.set_dir(1'b0);
    pins.pulse_event(1);
    rd_check(CNT, 32'h02, "hw up");
    apb(MODE, 1'b1, 32'h07);
    apb(CTRL, 1'b1, 32'h02);
    apb(CNT, 1'b1, 32'h10);
    pins.event_level(1'b1);
    rd_check(CNT, 32'h10, "no rise count");
    pins.event_level(1'b0);
    rd_check(CNT, 32'h11, "fall count");
    // enable low freezes filters and counter, so edges seen meanwhile are lost
    ceRun <= 1'b0;
    pins.pulse_event(2);
    ceRun <= 1'b1;
    rd_check(CNT, 32'h11, "ce freeze");
    haltReq <= 1'b1;
    pins.pulse_event(2);
    rd_check(CNT, 32'h11, "halt freeze");
    rd_check(MODE, 32'h1f, "mode kept");
    haltReq <= 1'b0;
    subClockMode <= 1'b1;
    apb(MODE, 1'b1, 32'h05);
    apb(CNT, 1'b1, 32'h40);
    repeat (40) @(posedge ref_clk);
    rd_check(CNT, 32'h40, "sub no div");
    apb(MODE, 1'b1, 32'h06);
    watchRun <= 1'b1;
    apb(CTRL, 1'b1, 32'h07);
    apb(CNT, 1'b1, 32'hfe);
    repeat (120) @(posedge ref_clk);
    rd_check(CTRL, 32'h07, "watch count");
    watchRun <= 1'b0;
    subClockMode <= 1'b0;
    // two ticks from fe can never finish inside one divider period
    for (int s = 0; s < 6; s++) begin
      apb(MODE, 1'b1, 32'(s));
      apb(CTRL, 1'b1, 32'h07);
      apb(CNT, 1'b1, 32'hfe);
      repeat (divs[s] - 3) @(posedge ref_clk);
      rd_check(CTRL, 32'h06, "early flag");
      repeat (2 * divs[s]) @(posedge ref_clk);
      rd_check(CTRL, 32'h07, "div flag");
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
